// *** src/dprs_seq_regs.vh ***
// constants for the dual phase ramp sequencer core
// assumes inclusion by dprs_sequencer.v only; values are plain numbers
`ifndef DPRS_SEQ_REGS_VH
`define DPRS_SEQ_REGS_VH

// clock and power-good timing
`define DPRS_CLK_PERIOD_NS   25
`define DPRS_PG_DELAY_NS     3000000
`define DPRS_PG_CNT_W        17

// four-level pin decode: ground, reference, high
`define DPRS_LVL_GND         2'h0
`define DPRS_LVL_REF         2'h1

// dac setting, one lsb is 25 mV
`define DPRS_DAC_W           6
`define DPRS_DAC_ZERO        6'h00
`define DPRS_DAC_STEP        6'h01
`define DPRS_VID_OFFSET      6'h01
`define DPRS_SUS_OFFSET      6'h01

// sequencer states
`define DPRS_SQ_OFF          3'h0
`define DPRS_SQ_WAIT_REF     3'h1
`define DPRS_SQ_RAMP         3'h2
`define DPRS_SQ_RUN          3'h3
`define DPRS_SQ_DOWN         3'h4

// phase states
`define DPRS_PH_IDLE         2'h0
`define DPRS_PH_ON           2'h1
`define DPRS_PH_OFF          2'h2
`define DPRS_PH_WAIT         2'h3

// phase identity
`define DPRS_PHASE_MAIN      1'b0
`define DPRS_PHASE_SEC       1'b1

// synchroniser bundle
`define DPRS_SYNC_W          16
`define DPRS_SYNC_STAGES_RST 16'h0000

`endif

// *** src/dprs_sync.v ***
// two flip-flop synchroniser for a bundle of slow pin inputs
// assumes the bits are static or change far slower than clk_in
module dprs_sync #(
   parameter W = 16
) (
   // clock and reset
   input  wire         clk_in,
   input  wire         arst_n_in,
   // pin side
   input  wire [W-1:0] async_in,
   // clock side
   output wire [W-1:0] sync_out
);
   reg [W-1:0] meta_q;
   reg [W-1:0] sync_q;

   // first stage feeds only the second stage
   always @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         meta_q <= {W{1'b0}};
         sync_q <= {W{1'b0}};
      end else begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end

   assign sync_out = sync_q;
endmodule

// *** src/dprs_sequencer.v ***
// digital control core of a two-phase step-down controller: phase
// alternation, transient overlap, power-up ramp and power-good timing
// assumes comparator flags are already on clk_in; pins are asynchronous
`include "dprs_seq_regs.vh"

// Notes on behaviour
// - dual-phase modes alternate single on-time pulses between main and secondary
// - in alternation the two high-side gates are never on together
// - dual-phase modes, output not above regulation at min off-time expiry: both highs on next
// - overlap persists until output is above regulation at min off-time expiry
// - after overlap, resume with phase opposite the last single pulse
// - enable raises reference first; switching starts only after reference ready
// - power-up ramps dac setting from zero by one 25 mV step per tick
// - target from vid code when state select is ground, else suspend code
// - power good low during ramp and 3 ms after reaching target
// - after power down the secondary low-side gate is forced high
// - mode select: high and reference both dual skip, ground single skip
// - power good blanked whenever the setting is being stepped
module dprs_sequencer #(
   parameter PG_DELAY_CYCLES =
      (`DPRS_PG_DELAY_NS + `DPRS_CLK_PERIOD_NS - 1) / `DPRS_CLK_PERIOD_NS
) (
   // clock and reset
   input  wire       clk_in,
   input  wire       arst_n_in,
   // enable and reference pins
   input  wire       shutdown_n_in,
   input  wire       ref_ready_in,
   input  wire       slew_tick_in,
   // mode and code pins (four-level pins decoded to two bits)
   input  wire [1:0] mode_select_in,
   input  wire [1:0] low_power_state_select_in,
   input  wire [4:0] vid_code_in,
   input  wire [3:0] suspend_code_in,
   // analog front-end flags, synchronous to clk_in
   input  wire       out_above_reg_in,
   input  wire       min_off_done_in,
   input  wire       on_time_done_in,
   // gate drivers
   output reg        main_high_gate_out,
   output reg        main_low_gate_out,
   output reg        secondary_high_gate_out,
   output reg        secondary_low_gate_out,
   // power good, open drain style
   output reg        power_good_out,
   output reg        power_good_oe_n_out,
   // status
   output reg  [5:0] dac_setting_out,
   output reg        slewing_out,
   output reg        overlap_out
);
   // count must stay below the counter range; upper bits cut on purpose
   localparam integer              PG_LAST_I = PG_DELAY_CYCLES - 1;
   localparam [`DPRS_PG_CNT_W-1:0] PG_LAST   = PG_LAST_I[`DPRS_PG_CNT_W-1:0];

   wire [`DPRS_SYNC_W-1:0] pins_s;
   wire                    shutdown_n_in_s;
   wire                    ref_s;
   wire                    tick_s;
   wire [1:0]              mode_s;
   wire [1:0]              lps_s;
   wire [4:0]              vid_s;
   wire [3:0]              sus_s;

   reg [2:0]                 sq_q;
   reg [2:0]                 sq_d;
   reg [`DPRS_DAC_W-1:0]     dac_q;
   reg [`DPRS_DAC_W-1:0]     dac_d;
   reg [`DPRS_PG_CNT_W-1:0]  pg_cnt_q;
   reg [`DPRS_PG_CNT_W-1:0]  pg_cnt_d;
   reg                       pg_done_q;
   reg                       pg_done_d;
   reg                       tick_dly_q;
   reg [1:0]                 ph_q;
   reg [1:0]                 ph_d;
   reg                       last_single_q;
   reg                       last_single_d;
   reg                       overlap_d;
   reg                       mh_d;
   reg                       sh_d;
   reg                       ml_d;
   reg                       sl_d;
   reg                       pg_d;

   wire                      tick_p;
   wire [`DPRS_DAC_W-1:0]    target;
   wire                      at_target;
   wire                      switching;
   wire                      dual;

   // settings are static pins, so plain two-flop capture is enough
   dprs_sync #(
      .W (`DPRS_SYNC_W)
   ) u_sync (
      .clk_in    (clk_in),
      .arst_n_in (arst_n_in),
      .async_in  ({shutdown_n_in, ref_ready_in, slew_tick_in, mode_select_in,
                   low_power_state_select_in, vid_code_in, suspend_code_in}),
      .sync_out  (pins_s)
   );

   assign shutdown_n_in_s = pins_s[15];
   assign ref_s  = pins_s[14];
   assign tick_s = pins_s[13];
   assign mode_s = pins_s[12:11];
   assign lps_s  = pins_s[10:9];
   assign vid_s  = pins_s[8:4];
   assign sus_s  = pins_s[3:0];

   assign tick_p = tick_s & ~tick_dly_q;

   // target code selection
   function [`DPRS_DAC_W-1:0] target_of;
      input [1:0] lps;
      input [4:0] vid;
      input [3:0] low_power_state_select;
      begin
         if (lps == `DPRS_LVL_GND) begin
            target_of = {1'b0, vid} + `DPRS_VID_OFFSET;
         end else begin
            target_of = {2'b00, low_power_state_select} + `DPRS_SUS_OFFSET;
         end
      end
   endfunction

   assign target    = target_of(lps_s, vid_s, sus_s);
   assign at_target = (dac_q == target);
   assign switching = (sq_q == `DPRS_SQ_RAMP) || (sq_q == `DPRS_SQ_RUN);
   // ground on mode select means single-phase
   assign dual      = (mode_s != `DPRS_LVL_GND);

   // power sequencing and dac slewing
   always @* begin
      sq_d      = sq_q;
      dac_d     = dac_q;
      pg_cnt_d  = pg_cnt_q;
      pg_done_d = pg_done_q;
      case (sq_q)
         `DPRS_SQ_OFF: begin
            dac_d     = `DPRS_DAC_ZERO;
            pg_done_d = 1'b0;
            if (shutdown_n_in_s) begin
               sq_d = `DPRS_SQ_WAIT_REF;
            end
         end
         `DPRS_SQ_WAIT_REF: begin
            // no switching and no target look until reference is ready
            if (ref_s) begin
               sq_d = `DPRS_SQ_RAMP;
            end
         end
         `DPRS_SQ_RAMP: begin
            // one lsb per slew tick from zero
            if (at_target) begin
               sq_d     = `DPRS_SQ_RUN;
               pg_cnt_d = {`DPRS_PG_CNT_W{1'b0}};
            end else if (tick_p) begin
               if (dac_q < target) begin
                  dac_d = dac_q + `DPRS_DAC_STEP;
               end else begin
                  dac_d = dac_q - `DPRS_DAC_STEP;
               end
            end
         end
         `DPRS_SQ_RUN: begin
            // hold-off after reaching target
            if (!pg_done_q) begin
               if (pg_cnt_q == PG_LAST) begin
                  pg_done_d = 1'b1;
               end else begin
                  pg_cnt_d = pg_cnt_q + 1'b1;
               end
            end
            // later code changes are slewed the same way
            if (!at_target && tick_p) begin
               if (dac_q < target) begin
                  dac_d = dac_q + `DPRS_DAC_STEP;
               end else begin
                  dac_d = dac_q - `DPRS_DAC_STEP;
               end
            end
         end
         `DPRS_SQ_DOWN: begin
            if (dac_q == `DPRS_DAC_ZERO) begin
               sq_d = `DPRS_SQ_OFF;
            end else if (tick_p) begin
               dac_d = dac_q - `DPRS_DAC_STEP;
            end
         end
         default: begin
            sq_d = `DPRS_SQ_OFF;
         end
      endcase
      if (!shutdown_n_in_s && sq_q != `DPRS_SQ_OFF && sq_q != `DPRS_SQ_DOWN) begin
         sq_d      = `DPRS_SQ_DOWN;
         pg_done_d = 1'b0;
      end
   end

   // phase control; flags read directly, no synchroniser
   always @* begin
      ph_d          = ph_q;
      last_single_d = last_single_q;
      overlap_d     = overlap_out;
      mh_d          = main_high_gate_out;
      sh_d          = secondary_high_gate_out;
      ml_d          = main_low_gate_out;
      sl_d          = secondary_low_gate_out;
      case (ph_q)
         `DPRS_PH_IDLE: begin
            mh_d      = 1'b0;
            sh_d      = 1'b0;
            overlap_d = 1'b0;
            if (switching) begin
               ph_d = `DPRS_PH_WAIT;
            end
         end
         `DPRS_PH_WAIT: begin
            if (!out_above_reg_in) begin
               ph_d = `DPRS_PH_ON;
               if (dual) begin
                  // one high at a time, alternating
                  last_single_d = ~last_single_q;
                  mh_d = (~last_single_q == `DPRS_PHASE_MAIN);
                  sh_d = (~last_single_q == `DPRS_PHASE_SEC);
               end else begin
                  last_single_d = `DPRS_PHASE_MAIN;
                  mh_d          = 1'b1;
                  sh_d          = 1'b0;
               end
               ml_d = ~mh_d;
               sl_d = ~sh_d;
            end
         end
         `DPRS_PH_ON: begin
            if (on_time_done_in) begin
               ph_d = `DPRS_PH_OFF;
               mh_d = 1'b0;
               sh_d = 1'b0;
               ml_d = 1'b1;
               sl_d = 1'b1;
            end
         end
         `DPRS_PH_OFF: begin
            if (min_off_done_in) begin
               if (dual && !out_above_reg_in) begin
                  // heavy transient: both phases in step
                  ph_d      = `DPRS_PH_ON;
                  overlap_d = 1'b1;
                  mh_d      = 1'b1;
                  sh_d      = 1'b1;
                  ml_d      = 1'b0;
                  sl_d      = 1'b0;
               end else begin
                  // last_single untouched by overlap pulses
                  ph_d      = `DPRS_PH_WAIT;
                  overlap_d = 1'b0;
               end
            end
         end
         default: begin
            ph_d = `DPRS_PH_IDLE;
         end
      endcase
      if (!switching) begin
         ph_d      = `DPRS_PH_IDLE;
         overlap_d = 1'b0;
         mh_d      = 1'b0;
         sh_d      = 1'b0;
         // lows forced high once powered down
         ml_d      = (sq_q == `DPRS_SQ_OFF);
         sl_d      = (sq_q == `DPRS_SQ_OFF);
      end
   end

   // released only in run, delay done and not slewing
   always @* begin
      pg_d = (sq_q == `DPRS_SQ_RUN) && pg_done_q && at_target && shutdown_n_in_s;
   end

   always @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         sq_q                    <= `DPRS_SQ_OFF;
         dac_q                   <= `DPRS_DAC_ZERO;
         pg_cnt_q                <= {`DPRS_PG_CNT_W{1'b0}};
         pg_done_q               <= 1'b0;
         tick_dly_q              <= 1'b0;
         ph_q                    <= `DPRS_PH_IDLE;
         last_single_q           <= `DPRS_PHASE_SEC;
         overlap_out             <= 1'b0;
         main_high_gate_out      <= 1'b0;
         secondary_high_gate_out <= 1'b0;
         main_low_gate_out       <= 1'b1;
         secondary_low_gate_out  <= 1'b1;
         power_good_out          <= 1'b0;
         power_good_oe_n_out     <= 1'b0;
         dac_setting_out         <= `DPRS_DAC_ZERO;
         slewing_out             <= 1'b0;
      end else begin
         sq_q                    <= sq_d;
         dac_q                   <= dac_d;
         pg_cnt_q                <= pg_cnt_d;
         pg_done_q               <= pg_done_d;
         tick_dly_q              <= tick_s;
         ph_q                    <= ph_d;
         last_single_q           <= last_single_d;
         overlap_out             <= overlap_d;
         main_high_gate_out      <= mh_d;
         secondary_high_gate_out <= sh_d;
         main_low_gate_out       <= ml_d;
         secondary_low_gate_out  <= sl_d;
         power_good_out          <= pg_d;
         // enable low means pulling the pin low
         power_good_oe_n_out     <= pg_d;
         dac_setting_out         <= dac_d;
         slewing_out             <= (dac_d != target) && (sq_d != `DPRS_SQ_OFF);
      end
   end
endmodule

// *** verif/dprs_seq_sva.sv ***
// port assertions for the dual phase ramp sequencer core
// assumes binding into dprs_sequencer; one clock domain, async reset
module dprs_seq_sva #(
   parameter PG_DELAY_CYCLES = 20
) (
   // clock and reset
   input wire       clk_in,
   input wire       arst_n_in,
   // watched ports
   input wire       ref_ready_in,
   input wire [1:0] mode_select_in,
   input wire       main_high_gate_out,
   input wire       main_low_gate_out,
   input wire       secondary_high_gate_out,
   input wire       secondary_low_gate_out,
   input wire       power_good_out,
   input wire       power_good_oe_n_out,
   input wire [5:0] dac_setting_out,
   input wire       slewing_out,
   input wire       overlap_out
);
   timeunit 1ns;
   timeprecision 100ps;
   reg [16:0] calm_q;
   reg        seen_q;
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!arst_n_in);
   // only the first release after power-up owes the long delay
   always @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         calm_q <= 17'h0_0000;
         seen_q <= 1'b0;
      end else begin
         calm_q <= slewing_out ? 17'h0_0000 : calm_q + 17'h0_0001;
         seen_q <= power_good_out | (seen_q & (dac_setting_out != 6'h00));
      end
   end
   a_highs_apart: assert property (
      !overlap_out |-> !(main_high_gate_out && secondary_high_gate_out))
      else $error("both high gates on outside overlap");
   a_overlap_both: assert property (
      $rose(overlap_out) |-> main_high_gate_out && secondary_high_gate_out)
      else $error("overlap began without both high gates");
   a_dac_one_step: assert property (
      !$stable(dac_setting_out) |-> (dac_setting_out - $past(dac_setting_out) == 6'h01) ||
      ($past(dac_setting_out) - dac_setting_out == 6'h01))
      else $error("dac setting moved by more than one step");
   a_pg_step_blank: assert property (
      !$stable(dac_setting_out) |-> !power_good_out)
      else $error("power good high while stepping");
   a_pg_long_wait: assert property (
      $rose(power_good_out) && !seen_q |-> calm_q >= PG_DELAY_CYCLES)
      else $error("power good released too early");
   a_pg_pin_pair: assert property (
      power_good_oe_n_out == power_good_out)
      else $error("power good enable disagrees with level");
   // the ramp starts switching at a zero setting, so watch the reference pin
   a_idle_gates: assert property (
      (!ref_ready_in)[*4] |-> !main_high_gate_out && !secondary_high_gate_out)
      else $error("switching before reference ready");
   a_off_lows: assert property (
      (dac_setting_out == 6'h00 && !slewing_out)[*3] |-> main_low_gate_out &&
      secondary_low_gate_out)
      else $error("low gates not forced high when off");
   a_single_main: assert property (
      (mode_select_in == 2'h0)[*8] |-> !secondary_high_gate_out && !overlap_out)
      else $error("secondary phase used in single phase mode");
endmodule

bind dprs_sequencer dprs_seq_sva #(.PG_DELAY_CYCLES(PG_DELAY_CYCLES)) dprs_seq_sva_i (.*);

// *** verif/dprs_stage_model.sv ***
// behavioural power stage: on-time, min off-time and regulation flags
// assumes the sequencer gate outputs; heavy load holds output low
module dprs_stage_model (
   // clock and reset
   input  wire clk_in,
   input  wire arst_n_in,
   // gates and load
   input  wire main_high_gate_out,
   input  wire secondary_high_gate_out,
   input  wire heavy_load_in,
   // comparator flags
   output wire out_above_reg_in,
   output wire min_off_done_in,
   output wire on_time_done_in
);
   timeunit 1ns;
   timeprecision 100ps;
   reg  [3:0] on_q;
   reg  [3:0] off_q;
   wire       hi = main_high_gate_out | secondary_high_gate_out;
   always @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         on_q  <= 4'h0;
         off_q <= 4'hf;
      end else begin
         on_q  <= hi ? on_q + 4'h1 : 4'h0;
         off_q <= hi ? 4'h0 : (off_q == 4'hf ? off_q : off_q + 4'h1);
      end
   end
   // output sags after a while off, so single pulses keep coming
   assign on_time_done_in  = hi && on_q >= 4'h3;
   assign min_off_done_in  = !hi && off_q >= 4'h2;
   assign out_above_reg_in = !heavy_load_in && !hi && off_q < 4'h8;
endmodule

// *** verif/test_dual_phase_ramp_sequencer.sv ***
// self-checking bench for the dual phase ramp sequencer core
// assumes dprs_stage_model as power stage; clock 40 MHz
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin err_total++; \
   $display("mismatch %s exp %h seen %h", n, e, s); end end
module test_dual_phase_ramp_sequencer;
   timeunit 1ns;
   timeprecision 100ps;
   localparam PG = 20;
   reg        clk_in                    = 1'b0;
   reg        arst_n_in                 = 1'b0;
   reg        shutdown_n_in             = 1'b0;
   reg        ref_ready_in              = 1'b0;
   reg        slew_tick_in              = 1'b0;
   reg        heavy_load_in             = 1'b0;
   reg  [1:0] mode_select_in            = 2'h2;
   reg  [1:0] low_power_state_select_in = 2'h0;
   reg  [4:0] vid_code_in               = 5'h04;
   reg  [3:0] suspend_code_in           = 4'h7;
   wire       out_above_reg_in, min_off_done_in, on_time_done_in;
   wire       main_high_gate_out, main_low_gate_out, secondary_high_gate_out;
   wire       secondary_low_gate_out, power_good_out, power_good_oe_n_out;
   wire       slewing_out, overlap_out;
   wire [5:0] dac_setting_out;
   integer    err_total = 0;
   integer    checked   = 0;
   integer    cycles    = 0;

   dprs_sequencer #(.PG_DELAY_CYCLES(PG)) dprs_sequencer_i (.*);
   dprs_stage_model dprs_stage_model_i (.*);

   initial forever #12.5 clk_in = ~clk_in;

   task report_and_stop;
      begin
         $display("checks %0d mismatches %0d", checked, err_total);
         if (err_total == 0 && checked > 0)
            $display("DONE - PASS");
         else
            $display("DONE - FAIL");
         $finish;
      end
   endtask

   // whole run needs about 600 cycles
   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 8000) begin
         err_total++;
         report_and_stop;
      end
   end

   // ticks are held long enough to pass the two-flop synchroniser
   task tick;
      begin
         repeat (4) @(posedge clk_in);
         slew_tick_in <= 1'b1;
         repeat (6) @(posedge clk_in);
         slew_tick_in <= 1'b0;
         #1;
      end
   endtask

   // next start of a high-side pulse, as {secondary, main}
   task pulse(output [1:0] ph);
      reg prev;
      begin
         ph = 2'h0;
         prev = main_high_gate_out | secondary_high_gate_out;
         while (ph == 2'h0) begin
            @(posedge clk_in);
            #1;
            if (!prev) ph = {secondary_high_gate_out, main_high_gate_out};
            prev = main_high_gate_out | secondary_high_gate_out;
         end
      end
   endtask

   task t_ramp;
      integer i;
      begin
         @(posedge clk_in) shutdown_n_in <= 1'b1;
         tick;
         `CHK("dac_wait_ref", 6'h00, dac_setting_out)
         @(posedge clk_in) ref_ready_in <= 1'b1;
         for (i = 1; i <= vid_code_in + 1; i++) begin
            tick;
            `CHK("ramp_step", i[5:0], dac_setting_out)
            `CHK("pg_ramp", 1'b0, power_good_out)
            `CHK("slewing", (i < vid_code_in + 1), slewing_out)
         end
         repeat (PG - 4) @(posedge clk_in);
         #1;
         `CHK("pg_delay", 1'b0, power_good_out)
         repeat (12) @(posedge clk_in);
         #1;
         `CHK("pg_release", 1'b1, power_good_oe_n_out)
      end
   endtask

   task t_alt(input [1:0] m);
      integer   i;
      reg [1:0] p;
      reg [1:0] q;
      begin
         @(posedge clk_in) mode_select_in <= m;
         pulse(q);
         for (i = 0; i < 5; i++) begin
            pulse(p);
            `CHK("alternate", ~q, p)
            q = p;
         end
      end
   endtask

   task t_ovl;
      reg [1:0] p;
      reg [1:0] last;
      begin
         pulse(last);
         @(posedge clk_in) heavy_load_in <= 1'b1;
         pulse(p);
         `CHK("overlap_start", 2'h3, p)
         pulse(p);
         `CHK("overlap_held", 2'h3, p)
         @(posedge clk_in) heavy_load_in <= 1'b0;
         pulse(p);
         `CHK("overlap_exit", ~last, p)
         `CHK("overlap_flag", 1'b0, overlap_out)
      end
   endtask

   // heavy load in the middle pass must not bring in overlap
   task t_single;
      integer   i;
      reg [1:0] p;
      begin
         @(posedge clk_in) mode_select_in <= 2'h0;
         pulse(p);
         for (i = 0; i < 3; i++) begin
            @(posedge clk_in) heavy_load_in <= (i == 1);
            pulse(p);
            `CHK("single_phase", 2'h1, p)
         end
      end
   endtask

   task t_sus;
      integer i;
      begin
         @(posedge clk_in) low_power_state_select_in <= 2'h1;
         for (i = vid_code_in + 2; i <= suspend_code_in + 1; i++) begin
            tick;
            `CHK("suspend_step", i[5:0], dac_setting_out)
         end
         repeat (6) @(posedge clk_in);
         #1;
         `CHK("pg_after_slew", 1'b1, power_good_out)
      end
   endtask

   task t_down;
      integer i;
      begin
         @(posedge clk_in) shutdown_n_in <= 1'b0;
         repeat (4) @(posedge clk_in);
         #1;
         `CHK("pg_shutdown", 1'b0, power_good_out)
         for (i = suspend_code_in + 1; i > 0; i--)
            tick;
         repeat (3) @(posedge clk_in);
         #1;
         `CHK("dac_down", 6'h00, dac_setting_out)
         `CHK("lows_off", 2'h3, {main_low_gate_out, secondary_low_gate_out})
      end
   endtask

   initial begin
      repeat (6) @(posedge clk_in);
      arst_n_in <= 1'b1;
      t_ramp;
      t_alt(2'h2);
      t_alt(2'h1);
      t_alt(2'h3);
      t_ovl;
      t_single;
      t_sus;
      t_down;
      report_and_stop;
   end
endmodule
